// >>> src/bsel_pkg.sv
// Shared constants, types and decode helpers of the boot select block
package bsel_pkg;

  // Program memory map
  localparam int          PM_AW         = 13;
  localparam logic [15:0] PM_TOP        = 16'h1FFF;
  localparam logic [15:0] ROM_BASE      = 16'hF000;
  localparam logic [12:0] FUSE_ADDR     = 13'h1FCF;
  localparam logic [12:0] PROBE_ADDR    = 13'h0000;
  localparam logic [7:0]  PROBE_BLANK0  = 8'h00;
  localparam logic [7:0]  PROBE_BLANK1  = 8'hFF;
  localparam logic [7:0]  RESERVED_OP   = 8'h00;

  // Configuration image
  localparam logic [5:0]  CFG_BYTES     = 6'h30;
  localparam logic [7:0]  RAM_CFG_BASE  = 8'h30;

  // RAM and user EEPROM geometry
  localparam int          WORD_W        = 24;
  localparam int          RAM_DEPTH     = 256;
  localparam int          UEE_DEPTH     = 128;
  localparam int          UEE_AW        = 7;

  // RAM map boundaries
  localparam logic [7:0]  STAT_LO       = 8'h10;
  localparam logic [7:0]  STAT_HI       = 8'h1F;
  localparam logic [7:0]  CFG_HI        = 8'h3F;
  localparam logic [7:0]  INT_LO        = 8'h51;
  localparam logic [7:0]  INT_HI        = 8'h55;
  localparam logic [7:0]  UART_LO       = 8'h56;
  localparam logic [7:0]  UART_HI       = 8'h5B;
  localparam logic [7:0]  RSV_LO        = 8'h5C;
  localparam logic [7:0]  RSV_HI        = 8'h5F;
  localparam logic [7:0]  USER_LO       = 8'h60;
  localparam logic [7:0]  USER_HI       = 8'hCF;
  localparam logic [7:0]  SYS_LO        = 8'hD0;
  localparam logic [7:0]  SYS_HI        = 8'hEF;
  localparam logic [7:0]  MIRROR_LO     = 8'hF0;

  typedef enum logic [1:0] {
    BS_PROBE = 2'b00,
    BS_LOAD  = 2'b01,
    BS_DONE  = 2'b10
  } bsel_state_t;

  typedef enum logic [2:0] {
    RG_LOW    = 3'b000,
    RG_STATUS = 3'b001,
    RG_CONFIG = 3'b010,
    RG_INTREG = 3'b011,
    RG_UART   = 3'b100,
    RG_RSVD   = 3'b101,
    RG_SYSTEM = 3'b110,
    RG_MIRROR = 3'b111
  } bsel_region_t;

  // Byte request toward a program memory or ROM
  typedef struct packed {
    logic             req;
    logic             we;
    logic [15:0]      addr;
    logic [7:0]       wdata;
  } bsel_mreq_t;

  // Byte answer from a program memory or ROM
  typedef struct packed {
    logic             valid;
    logic [7:0]       data;
  } bsel_mrsp_t;

  // Classify a RAM pointer value
  function automatic bsel_region_t ram_region(input logic [7:0] a);
    if (a >= MIRROR_LO)                  return RG_MIRROR;
    else if (a >= SYS_LO)                return RG_SYSTEM;
    else if (a >= USER_LO || a <= STAT_LO - 8'h01) return RG_LOW;
    else if (a >= RSV_LO)                return RG_RSVD;
    else if (a >= UART_LO)               return RG_UART;
    else if (a >= INT_LO)                return RG_INTREG;
    else if (a <= STAT_HI)               return RG_STATUS;
    else if (a >= RAM_CFG_BASE && a <= CFG_HI) return RG_CONFIG;
    else                                 return RG_LOW;
  endfunction

  // Physical word for a pointer: the top sixteen alias the status block
  function automatic logic [7:0] ram_phys(input logic [7:0] a);
    return (a >= MIRROR_LO) ? (STAT_LO | (a & 8'h0F)) : a;
  endfunction

endpackage

// >>> src/bsel_mem.sv
// Single port memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module bsel_mem #(
  parameter int W  = 24,
  parameter int D  = 256,
  parameter int AW = 8
) (
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [W-1:0]  wdata,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem_r [D];

  ////////////////////////////////////////////////////////////////////////
  // Array write, no reset on the storage itself
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem_r[addr] <= wdata;
    end
  end

  // Read data register, defined from reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= '0;
    end else begin
      rdata <= mem_r[addr];
    end
  end
endmodule
`default_nettype wire

// >>> src/bsel_fuse.sv
// Read protection state of the one-time-programmable memory
`timescale 1ns/1ns
`default_nettype none
module bsel_fuse
  import bsel_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          done_wr,
  input  wire logic          done_rd,
  input  wire logic [12:0]   done_addr,
  input  wire logic [7:0]    done_wdata,
  input  wire logic [7:0]    done_rdata,
  output logic               prot,
  output logic               armed
);
  typedef struct packed {
    logic prot;
    logic armed;
  } bsel_fuse_st_t;

  bsel_fuse_st_t s_r;
  bsel_fuse_st_t s_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Next state from completed host accesses of the fuse byte
  always_comb begin
    s_nxt = s_r;
    if (done_wr && done_addr == FUSE_ADDR && done_wdata != 8'h00) begin
      s_nxt.armed = 1'b1;
    end
    if (done_rd && done_addr == FUSE_ADDR) begin
      s_nxt.prot  = (done_rdata != 8'h00);
      s_nxt.armed = 1'b0;
    end
  end

  // Starts protected after reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '{prot: 1'b1, armed: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prot  = s_r.prot;
  assign armed = s_r.armed;
endmodule
`default_nettype wire

// >>> src/bsel_top.sv
// Program memory selection, configuration load and RAM/user EEPROM access
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Non-zero fuse write arms read protection
// - Following fuse read completes the protection
// - External EEPROM up to 8 kB accepted
// - Same fetch semantics from either source
// - Probe byte 00 or FF selects OTP
// - Any other probe value selects EEPROM
// - Probe byte is config word 0 top
// - Lowest 48 bytes are configuration image
// - Three bytes form one 24-bit word
// - Sixteen words land in RAM 48-63
// - EEPROM fetch is much slower
// - 4 kB ROM from F000, return allowed
// - 128-byte user EEPROM, byte get/put
// - RAM pointer also addresses user EEPROM
// - RAM 240-255 mirror words 16-31
// - Fixed RAM map regions decoded
// - OTP read-protected after power-on
// - Fuse read unprotects only when zero
module bsel_top
  import bsel_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // Internal OTP byte port
  output bsel_pkg::bsel_mreq_t      otp_req,
  input  wire bsel_pkg::bsel_mrsp_t otp_rsp,
  // External EEPROM byte port
  output bsel_pkg::bsel_mreq_t      ext_req,
  input  wire bsel_pkg::bsel_mrsp_t ext_rsp,
  // ROM byte port
  output bsel_pkg::bsel_mreq_t      rom_req,
  input  wire bsel_pkg::bsel_mrsp_t rom_rsp,
  // Host access to the OTP
  input  wire bsel_pkg::bsel_mreq_t host_req,
  output logic                      host_ack,
  output logic [7:0]                host_rdata,
  output logic                      otp_prot,
  output logic                      fuse_armed,
  // CPU instruction fetch
  input  wire logic                 fetch_req,
  input  wire logic [15:0]          fetch_addr,
  output logic                      fetch_valid,
  output logic [7:0]                fetch_data,
  output logic                      boot_done,
  output logic                      ext_selected,
  // CPU RAM and user EEPROM access
  input  wire logic [7:0]           ram_ptr,
  input  wire logic                 epr_op,
  input  wire logic                 ram_we,
  input  wire logic [WORD_W-1:0]    ram_wdata,
  output logic [WORD_W-1:0]         ram_rdata,
  output logic [7:0]                epr_rdata,
  output bsel_pkg::bsel_region_t    ram_region_q
);

  // Who holds the OTP port after boot
  typedef enum logic [1:0] {
    OW_NONE  = 2'b00,
    OW_HOST  = 2'b01,
    OW_FETCH = 2'b10
  } bsel_owner_t;

  typedef enum logic [1:0] {
    FS_PM   = 2'b00,
    FS_ROM  = 2'b01,
    FS_RSVD = 2'b10
  } bsel_fsrc_t;

  typedef struct packed {
    bsel_state_t  st;
    logic         use_ext;
    logic [5:0]   idx;
    logic [1:0]   pos;
    logic [15:0]  acc;
    logic [3:0]   word;
    bsel_owner_t  own;
    logic         fbusy;
    bsel_fsrc_t   fsrc;
    logic         fvalid;
    logic [7:0]   fdata;
    logic         hack;
    logic [7:0]   hdata;
    bsel_region_t region;
  } bsel_top_st_t;

  bsel_top_st_t s_r;
  bsel_top_st_t s_nxt;

  logic              ld_we;
  logic [WORD_W-1:0] ld_word;
  logic [7:0]        ram_addr;
  logic              ram_wen;
  logic [WORD_W-1:0] ram_wd;
  logic              epr_wen;
  logic              host_wr_done;
  logic              host_rd_done;
  logic              pm_valid;
  logic [7:0]        pm_data;
  logic              boot_src_valid;
  logic [7:0]        boot_src_data;

  ////////////////////////////////////////////////////////////////////////
  // Response of the selected program source
  always_comb begin
    pm_valid = s_r.use_ext ? ext_rsp.valid : otp_rsp.valid;
    pm_data  = s_r.use_ext ? ext_rsp.data  : otp_rsp.data;
  end

  // Boot reads the EEPROM while probing, the chosen source while loading
  always_comb begin
    boot_src_valid = (s_r.st == BS_PROBE) ? ext_rsp.valid : pm_valid;
    boot_src_data  = (s_r.st == BS_PROBE) ? ext_rsp.data  : pm_data;
  end

  // Host completions as seen on the OTP port
  assign host_wr_done = (s_r.own == OW_HOST) && otp_rsp.valid && host_req.we;
  assign host_rd_done = (s_r.own == OW_HOST) && otp_rsp.valid && !host_req.we;

  // Word assembly: earliest byte in the top lane
  assign ld_word = {s_r.acc, boot_src_data};
  assign ld_we   = (s_r.st == BS_LOAD) && boot_src_valid && (s_r.pos == 2'd2);

  ////////////////////////////////////////////////////////////////////////
  // Main next-state process
  always_comb begin
    s_nxt        = s_r;
    s_nxt.fvalid = 1'b0;
    s_nxt.hack   = 1'b0;
    s_nxt.region = ram_region(ram_ptr);

    case (s_r.st)
      BS_PROBE: begin
        if (ext_rsp.valid) begin
          if (ext_rsp.data == PROBE_BLANK0 || ext_rsp.data == PROBE_BLANK1) begin
            s_nxt.use_ext = 1'b0;
            s_nxt.idx     = 6'd0;
            s_nxt.pos     = 2'd0;
          end else begin
            // Probe byte is reused as byte 0 of the image
            s_nxt.use_ext = 1'b1;
            s_nxt.acc     = {ext_rsp.data, 8'h00};
            s_nxt.idx     = 6'd1;
            s_nxt.pos     = 2'd1;
          end
          s_nxt.word = 4'd0;
          s_nxt.st   = BS_LOAD;
        end
      end
      BS_LOAD: begin
        if (boot_src_valid) begin
          if (s_r.pos == 2'd0) begin
            s_nxt.acc[15:8] = boot_src_data;
          end else if (s_r.pos == 2'd1) begin
            s_nxt.acc[7:0] = boot_src_data;
          end
          s_nxt.pos = (s_r.pos == 2'd2) ? 2'd0 : s_r.pos + 2'd1;
          s_nxt.idx = s_r.idx + 6'd1;
          if (s_r.pos == 2'd2) begin
            s_nxt.word = s_r.word + 4'd1;
          end
          if (s_r.idx == CFG_BYTES - 6'd1) begin
            s_nxt.st = BS_DONE;
          end
        end
      end
      BS_DONE: begin
        // Instruction fetch: decode the program address once per request
        if (!s_r.fbusy && fetch_req) begin
          s_nxt.fbusy = 1'b1;
          if (fetch_addr >= ROM_BASE) begin
            s_nxt.fsrc = FS_ROM;
          end else if (fetch_addr <= PM_TOP) begin
            s_nxt.fsrc = FS_PM;
          end else begin
            s_nxt.fsrc = FS_RSVD;
          end
        end
        if (s_r.fbusy) begin
          case (s_r.fsrc)
            FS_ROM: begin
              if (rom_rsp.valid) begin
                s_nxt.fbusy  = 1'b0;
                s_nxt.fvalid = 1'b1;
                s_nxt.fdata  = rom_rsp.data;
              end
            end
            FS_PM: begin
              // External source answers after many more cycles
              if (pm_valid && (s_r.use_ext || s_r.own == OW_FETCH)) begin
                s_nxt.fbusy  = 1'b0;
                s_nxt.fvalid = 1'b1;
                s_nxt.fdata  = pm_data;
              end
            end
            default: begin
              s_nxt.fbusy  = 1'b0;
              s_nxt.fvalid = 1'b1;
              s_nxt.fdata  = RESERVED_OP;
            end
          endcase
        end
        // OTP port arbitration between host and internal fetch
        if (s_r.own == OW_NONE) begin
          if (host_req.req) begin
            s_nxt.own = OW_HOST;
          end else if (s_r.fbusy && s_r.fsrc == FS_PM && !s_r.use_ext) begin
            s_nxt.own = OW_FETCH;
          end
        end else if (otp_rsp.valid) begin
          s_nxt.own = OW_NONE;
        end
        // Host answer, blanked while protected except for the fuse byte
        if (s_r.own == OW_HOST && otp_rsp.valid) begin
          s_nxt.hack = 1'b1;
          if (otp_prot && host_req.addr[12:0] != FUSE_ADDR) begin
            s_nxt.hdata = 8'h00;
          end else begin
            s_nxt.hdata = otp_rsp.data;
          end
        end
      end
      default: begin
        s_nxt.st = BS_PROBE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '{st: BS_PROBE, use_ext: 1'b0, idx: 6'd0, pos: 2'd0, acc: 16'h0000,
               word: 4'd0, own: OW_NONE, fbusy: 1'b0, fsrc: FS_PM, fvalid: 1'b0,
               fdata: 8'h00, hack: 1'b0, hdata: 8'h00, region: RG_LOW};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program source requests
  always_comb begin
    otp_req = '0;
    ext_req = '0;
    rom_req = '0;
    if (s_r.st == BS_PROBE) begin
      ext_req.req  = 1'b1;
      ext_req.addr = {3'b000, PROBE_ADDR};
    end else if (s_r.st == BS_LOAD) begin
      // Boot reads bypass the protection of the OTP
      if (s_r.use_ext) begin
        ext_req.req  = 1'b1;
        ext_req.addr = {10'h000, s_r.idx};
      end else begin
        otp_req.req  = 1'b1;
        otp_req.addr = {10'h000, s_r.idx};
      end
    end else begin
      if (s_r.fbusy && s_r.fsrc == FS_ROM) begin
        rom_req.req  = 1'b1;
        rom_req.addr = fetch_addr - ROM_BASE;
      end
      if (s_r.fbusy && s_r.fsrc == FS_PM && s_r.use_ext) begin
        ext_req.req  = 1'b1;
        ext_req.addr = {3'b000, fetch_addr[12:0]};
      end
      if (s_r.own == OW_HOST) begin
        otp_req = host_req;
        otp_req.addr = {3'b000, host_req.addr[12:0]};
      end else if (s_r.own == OW_FETCH) begin
        otp_req.req  = 1'b1;
        otp_req.addr = {3'b000, fetch_addr[12:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // RAM port: loader during boot, CPU afterwards
  always_comb begin
    if (s_r.st == BS_LOAD) begin
      ram_addr = RAM_CFG_BASE + {4'h0, s_r.word};
      ram_wen  = ld_we;
      ram_wd   = ld_word;
    end else begin
      ram_addr = ram_phys(ram_ptr);
      ram_wen  = boot_done && ram_we && !epr_op;
      ram_wd   = ram_wdata;
    end
  end

  // User EEPROM shares the pointer, only put/get reach it
  assign epr_wen = boot_done && ram_we && epr_op;

  bsel_mem #(
    .W  (WORD_W),
    .D  (RAM_DEPTH),
    .AW (8)
  ) u_ram (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .we       (ram_wen),
    .addr     (ram_addr),
    .wdata    (ram_wd),
    .rdata    (ram_rdata)
  );

  bsel_mem #(
    .W  (8),
    .D  (UEE_DEPTH),
    .AW (UEE_AW)
  ) u_uee (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .we       (epr_wen),
    .addr     (ram_ptr[UEE_AW-1:0]),
    .wdata    (ram_wdata[7:0]),
    .rdata    (epr_rdata)
  );

  bsel_fuse u_fuse (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .done_wr    (host_wr_done),
    .done_rd    (host_rd_done),
    .done_addr  (host_req.addr[12:0]),
    .done_wdata (host_req.wdata),
    .done_rdata (otp_rsp.data),
    .prot       (otp_prot),
    .armed      (fuse_armed)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign boot_done    = (s_r.st == BS_DONE);
  assign ext_selected = s_r.use_ext;
  assign fetch_valid  = s_r.fvalid;
  assign fetch_data   = s_r.fdata;
  assign host_ack     = s_r.hack;
  assign host_rdata   = s_r.hdata;
  assign ram_region_q = s_r.region;

endmodule
`default_nettype wire

// >>> test/bsel_byte_model.sv
// Behavioural byte memory standing behind one program memory or ROM port
`timescale 1ns/1ns
`default_nettype none
module bsel_byte_model #(
  parameter int LAT = 1
) (
  input  wire logic                 core_clk,
  input  wire bsel_pkg::bsel_mreq_t req,
  output var  bsel_pkg::bsel_mrsp_t rsp
);
  import bsel_pkg::*;
  logic [7:0] mem [0:8191];
  logic [7:0] last = 8'h00;
  int         cnt = 0;

  initial rsp = '0;

  // Answer a held request after LAT edges; idle data shows the inverse of the last byte
  always @(posedge core_clk) begin
    rsp.valid <= 1'b0;
    rsp.data <= ~last;
    if (req.req && !rsp.valid) begin
      if (cnt == LAT - 1) begin
        cnt <= 0;
        rsp.valid <= 1'b1;
        rsp.data <= mem[req.addr[12:0]];
        last <= mem[req.addr[12:0]];
        if (req.we) begin
          mem[req.addr[12:0]] <= req.wdata;
        end
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/bsel_top_props.sv
// Concurrent checks on the boot select top ports
`timescale 1ns/1ns
`default_nettype none
module bsel_top_props (
  input wire logic                   core_clk,
  input wire logic                   sys_rst,
  input wire bsel_pkg::bsel_mreq_t   otp_req,
  input wire bsel_pkg::bsel_mrsp_t   otp_rsp,
  input wire bsel_pkg::bsel_mreq_t   ext_req,
  input wire bsel_pkg::bsel_mrsp_t   ext_rsp,
  input wire bsel_pkg::bsel_mreq_t   rom_req,
  input wire logic                   host_ack,
  input wire logic                   otp_prot,
  input wire logic                   fuse_armed,
  input wire logic [15:0]            fetch_addr,
  input wire logic                   fetch_valid,
  input wire logic                   boot_done,
  input wire logic                   ext_selected,
  input wire logic [7:0]             ram_ptr,
  input wire bsel_pkg::bsel_region_t ram_region_q
);
  import bsel_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic last_byte;
  logic fuse_hit;
  logic blank;

  // Final image byte answered, any OTP access (host or fetch) answered at the fuse after boot, blank probe value
  assign last_byte = !boot_done && ((otp_req.req && otp_rsp.valid && otp_req.addr == 16'd47) ||
                     (ext_req.req && ext_rsp.valid && ext_req.addr == 16'd47));
  assign fuse_hit = boot_done && otp_req.req && otp_rsp.valid && otp_req.addr == {3'b000, FUSE_ADDR};
  assign blank = ext_rsp.data == PROBE_BLANK0 || ext_rsp.data == PROBE_BLANK1;

  ////////////////////////////////////////////////////////////////
  sequence s_probe;
    !boot_done && ext_req.req && ext_req.addr == 16'h0000 && ext_rsp.valid;
  endsequence
  property p_probe_start;
    $fell(sys_rst) |-> ext_req.req && ext_req.addr == 16'h0000;
  endproperty
  property p_sel_otp;
    s_probe ##0 blank |=> !ext_selected && otp_req.req && otp_req.addr == 16'h0000;
  endproperty
  property p_sel_ext;
    s_probe ##0 !blank |=> ext_selected;
  endproperty
  property p_load_next;
    !boot_done && otp_req.req && otp_rsp.valid && otp_req.addr < 16'd47
      |=> otp_req.req && otp_req.addr == $past(otp_req.addr) + 16'd1;
  endproperty
  property p_boot_end;
    last_byte |-> ##[1:2] boot_done;
  endproperty
  property p_fetch_gate;
    fetch_valid |-> boot_done;
  endproperty
  property p_rom_map;
    rom_req.req |-> boot_done && fetch_addr >= ROM_BASE && rom_req.addr == fetch_addr - ROM_BASE;
  endproperty
  property p_host_ack;
    host_ack |-> $past(otp_rsp.valid) && boot_done;
  endproperty
  property p_arm;
    fuse_hit && otp_req.we && otp_req.wdata != 8'h00 |=> fuse_armed;
  endproperty
  property p_fuse_rd;
    fuse_hit && !otp_req.we |=> !fuse_armed && otp_prot == ($past(otp_rsp.data) != 8'h00);
  endproperty
  property p_prot_rst;
    $fell(sys_rst) |-> otp_prot && !boot_done;
  endproperty
  property p_mirror;
    !$past(sys_rst) |-> ((ram_region_q == RG_MIRROR) == ($past(ram_ptr) >= MIRROR_LO));
  endproperty

  ////////////////////////////////////////////////////////////////
  a_probe_start: assert property (p_probe_start)
    else $error("probe of byte 0 missing");
  a_sel_otp: assert property (p_sel_otp)
    else $error("blank probe did not select internal memory");
  a_sel_ext: assert property (p_sel_ext)
    else $error("probe did not select external memory");
  a_load_next: assert property (p_load_next)
    else $error("image bytes not read in order");
  a_boot_end: assert property (p_boot_end)
    else $error("boot did not finish after last byte");
  a_fetch_gate: assert property (p_fetch_gate)
    else $error("fetch answered before boot");
  a_rom_map: assert property (p_rom_map)
    else $error("rom address wrong");
  a_host_ack: assert property (p_host_ack)
    else $error("host ack without memory answer");
  a_arm: assert property (p_arm)
    else $error("fuse write did not arm");
  a_fuse_rd: assert property (p_fuse_rd)
    else $error("fuse read gave wrong protection");
  a_prot_rst: assert property (p_prot_rst)
    else $error("memory not protected after reset");
  a_mirror: assert property (p_mirror)
    else $error("mirror region decode wrong");
endmodule
`default_nettype wire

// >>> test/bsel_top_tb_top.sv
// Self-checking bench for the boot select top
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module bsel_top_tb_top;
  import bsel_pkg::*;
  logic              core_clk = 1'b0;
  logic              sys_rst = 1'b1;
  bsel_mreq_t        otp_req, ext_req, rom_req;
  bsel_mreq_t        host_req = '0;
  bsel_mrsp_t        otp_rsp, ext_rsp, rom_rsp;
  logic              host_ack, otp_prot, fuse_armed, fetch_valid, boot_done, ext_selected;
  logic              fetch_req = 1'b0;
  logic              epr_op = 1'b0;
  logic              ram_we = 1'b0;
  logic [7:0]        ram_ptr = 8'h00;
  logic [7:0]        host_rdata, fetch_data, epr_rdata;
  logic [7:0]        probe;
  logic [15:0]       fetch_addr = 16'h0000;
  logic [WORD_W-1:0] ram_wdata = '0;
  logic [WORD_W-1:0] ram_rdata;
  bsel_region_t      ram_region_q;
  int                error_cnt = 0;
  int                n_checks = 0;
  int                cyc = 0;
  logic [7:0]        rp [18] = '{8'h00, 8'h10, 8'h1F, 8'h30, 8'h3F, 8'h50, 8'h51, 8'h55, 8'h56,
                                 8'h5B, 8'h5C, 8'h5F, 8'h60, 8'hCF, 8'hD0, 8'hEF, 8'hF0, 8'hFF};
  bsel_region_t      rg [18] = '{RG_LOW, RG_STATUS, RG_STATUS, RG_CONFIG, RG_CONFIG, RG_LOW, RG_INTREG,
                                 RG_INTREG, RG_UART, RG_UART, RG_RSVD, RG_RSVD, RG_LOW, RG_LOW,
                                 RG_SYSTEM, RG_SYSTEM, RG_MIRROR, RG_MIRROR};

  bsel_top u_bsel_top (.core_clk, .sys_rst, .otp_req, .otp_rsp, .ext_req, .ext_rsp, .rom_req, .rom_rsp,
    .host_req, .host_ack, .host_rdata, .otp_prot, .fuse_armed, .fetch_req, .fetch_addr, .fetch_valid,
    .fetch_data, .boot_done, .ext_selected, .ram_ptr, .epr_op, .ram_we, .ram_wdata, .ram_rdata,
    .epr_rdata, .ram_region_q);
  bsel_byte_model #(.LAT(1)) u_otp_model (.core_clk, .req(otp_req), .rsp(otp_rsp));
  bsel_byte_model #(.LAT(3)) u_ext_model (.core_clk, .req(ext_req), .rsp(ext_rsp));
  bsel_byte_model #(.LAT(2)) u_rom_model (.core_clk, .req(rom_req), .rsp(rom_rsp));

  // Clock and hang limit
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Memory contents: 0 internal, 1 external, 2 ROM
  function automatic logic [7:0] pat(input int s, input int i);
    logic [12:0] a;
    a = i[12:0];
    if (s == 2) return a[7:0] ^ 8'h5A;
    if (s == 1) return (a == 13'h0000) ? probe : a[7:0] + 8'h11;
    return (a == FUSE_ADDR) ? 8'h00 : a[7:0] ^ 8'h3C;
  endfunction

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic ram_acc(input logic [7:0] p, input logic e, input logic w, input logic [23:0] d);
    ram_ptr = p;
    epr_op = e;
    ram_we = w;
    ram_wdata = d;
    tick();
  endtask

  task automatic fetch_chk(input logic [15:0] a, input logic [7:0] e);
    int n;
    fetch_addr = a;
    fetch_req = 1'b1;
    tick();
    for (n = 0; n < 200 && fetch_valid !== 1'b1; n++) tick();
    fetch_req = 1'b0;
    `CHK(fetch_valid, 1'b1)
    `CHK(fetch_data, e)
    tick();
  endtask

  task automatic host_acc(input logic w, input logic [12:0] a, input logic [7:0] d, input logic [7:0] e);
    int n;
    host_req = '{req: 1'b1, we: w, addr: {3'b000, a}, wdata: d};
    tick();
    for (n = 0; n < 200 && host_ack !== 1'b1; n++) tick();
    host_req.req = 1'b0;
    `CHK(host_ack, 1'b1)
    if (!w) `CHK(host_rdata, e)
    tick();
  endtask

  ////////////////////////////////////////////////////////////////
  // Power-up with a given probe byte, image copy, then fetches from every space
  task automatic t_boot_select(input logic [7:0] p);
    int n;
    int k;
    logic s;
    s = (p != 8'h00 && p != 8'hFF);
    sys_rst = 1'b1;
    probe = p;
    u_ext_model.mem[0] = p;
    fetch_req = 1'b1;
    repeat (4) tick();
    sys_rst = 1'b0;
    for (n = 0; n < 1000 && boot_done !== 1'b1; n++) tick();
    fetch_req = 1'b0;
    `CHK(boot_done, 1'b1)
    `CHK(fetch_valid, 1'b0)
    `CHK(ext_selected, s)
    for (k = 0; k < 16; k++) begin
      ram_acc(RAM_CFG_BASE + k[7:0], 1'b0, 1'b0, 24'h0);
      `CHK(ram_rdata, {pat(s, 3*k), pat(s, 3*k+1), pat(s, 3*k+2)})
    end
    fetch_chk(16'h0100, pat(s, 16'h0100));
    fetch_chk(16'h1FFF, pat(s, 16'h1FFF));
    fetch_chk(16'hF000, pat(2, 0));
    fetch_chk(16'hFFFF, pat(2, 16'h0FFF));
    fetch_chk(16'h3000, RESERVED_OP);
  endtask

  // Mirror, user byte store sharing the pointer, and the region map
  task automatic t_ram();
    int k;
    ram_acc(STAT_LO, 1'b0, 1'b1, 24'h123456);
    ram_acc(8'hF0, 1'b0, 1'b0, 24'h0);
    `CHK(ram_rdata, 24'h123456)
    ram_acc(8'hFF, 1'b0, 1'b1, 24'hABCDEF);
    ram_acc(STAT_HI, 1'b0, 1'b0, 24'h0);
    `CHK(ram_rdata, 24'hABCDEF)
    ram_acc(8'h04, 1'b1, 1'b1, 24'h0000C3);
    ram_acc(8'h04, 1'b0, 1'b1, 24'h777777);
    ram_acc(8'h84, 1'b1, 1'b0, 24'h0);
    `CHK(epr_rdata, 8'hC3)
    ram_acc(8'h04, 1'b0, 1'b0, 24'h0);
    `CHK(ram_rdata, 24'h777777)
    for (k = 0; k < 18; k++) begin
      ram_acc(rp[k], 1'b0, 1'b0, 24'h0);
      `CHK(ram_region_q, rg[k])
    end
  endtask

  // Unprotect on a blank fuse, then arm and complete protection
  task automatic t_fuse();
    host_acc(1'b0, 13'h0005, 8'h00, 8'h00);
    `CHK(otp_prot, 1'b1)
    host_acc(1'b0, FUSE_ADDR, 8'h00, 8'h00);
    `CHK(otp_prot, 1'b0)
    host_acc(1'b0, 13'h0005, 8'h00, pat(0, 5));
    host_acc(1'b1, FUSE_ADDR, 8'h01, 8'h00);
    `CHK({fuse_armed, otp_prot}, 2'b10)
    host_acc(1'b0, 13'h0005, 8'h00, pat(0, 5));
    host_acc(1'b0, FUSE_ADDR, 8'h00, 8'h01);
    `CHK({fuse_armed, otp_prot}, 2'b01)
    host_acc(1'b0, 13'h0005, 8'h00, 8'h00);
  endtask

  // Main sequence
  initial begin
    for (int i = 0; i < 8192; i++) begin
      u_otp_model.mem[i] = pat(0, i);
      u_ext_model.mem[i] = pat(1, i);
      u_rom_model.mem[i] = pat(2, i);
    end
    t_boot_select(8'h5A);
    t_boot_select(8'hFF);
    t_boot_select(8'h00);
    t_ram();
    t_fuse();
    report_and_stop();
  end
endmodule

bind bsel_top bsel_top_props u_bsel_top_props (.core_clk, .sys_rst, .otp_req, .otp_rsp, .ext_req, .ext_rsp,
  .rom_req, .host_ack, .otp_prot, .fuse_armed, .fetch_addr, .fetch_valid, .boot_done, .ext_selected,
  .ram_ptr, .ram_region_q);
`default_nettype wire
